// ==== logic/ccf_finder.sv ====
// Level-2 calorimeter cluster finder: buffers, seed search, growth, sums.
// Assumes the digitizer, supervisor and processors all run on clk.
`timescale 1ns/1ps

// Contract
// RULE_01: Flag seed and shoulder per tower first.
// RULE_02: Clusters start at seeds, add contiguous shoulders.
// RULE_03: Pick seed with lowest eta, then phi.
// RULE_04: Chosen seed sends found to four neighbours.
// RULE_05: Found shoulder tower forwards found onward.
// RULE_06: Cluster done when no unfound shoulder adjoins.
// RULE_07: Found towers and absorbed seeds stay excluded.
// RULE_08: Completed cluster energies enter the adder tree.
// RULE_09: Repeat poll, grow, sum until none left.
// RULE_10: Summing overlaps next seed search and growth.
// RULE_11: Report EM, HAD, count, seed eta, phi.
// RULE_12: No energy-weighted positions are computed.
// RULE_13: Hold crossing data, latch into four buffers.
// RULE_14: Start finding as soon as buffer address arrives.
// RULE_15: New buffer only after current one finishes.
// RULE_16: Occupied buffers refuse accepts; all full, deadtime.
// RULE_17: Array of 1152 towers, half EM, half HAD.
// RULE_18: Board sums over eight EM, eight HAD towers.
// RULE_19: Crate sums feed one master sum.
// RULE_20: Cluster address to expansion, separate read path.
// RULE_21: Phi wraps around, eta edges have no neighbour.
// RULE_22: Clear found flags before each new buffer.
module ccf_finder
  import ccf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              tw_we,
  input  wire logic [IDXW-1:0]   tw_idx,
  input  wire logic [EW-1:0]     tw_em,
  input  wire logic [EW-1:0]     tw_had,
  input  wire logic              l1_accept,
  input  wire logic [BUFW-1:0]   l1_buf,
  input  wire logic              l2_release,
  input  wire logic [BUFW-1:0]   l2_release_buf,
  input  wire logic              proc_req,
  input  wire logic [BUFW-1:0]   proc_buf,
  input  wire logic [EW:0]       seed_thr,
  input  wire logic [EW:0]       shldr_thr,
  input  wire logic [IDXW-1:0]   xp_rd_idx,
  output logic                   l1_refused,
  output logic                   deadtime,
  output logic [NBUF-1:0]        buf_busy,
  output logic                   finder_busy,
  output logic                   event_done,
  output logic                   clu_valid,
  output logic [SUMW-1:0]        clu_em,
  output logic [SUMW-1:0]        clu_had,
  output logic [CNTW-1:0]        clu_count,
  output logic [AW-1:0]          clu_eta,
  output logic [AW-1:0]          clu_phi,
  output logic                   xp_addr_valid,
  output logic [AW-1:0]          xp_eta,
  output logic [AW-1:0]          xp_phi,
  output logic [EW-1:0]          xp_em,
  output logic [EW-1:0]          xp_had
);

  // ----------------------------------------
  // Tower memories
  // ----------------------------------------
  // Crossing hold is one crossing deep: an accept latches the last frame
  logic [EW-1:0] xing_em  [NPOS];
  logic [EW-1:0] xing_had [NPOS];
  logic [EW-1:0] l2_em    [NBUF][NPOS];
  logic [EW-1:0] l2_had   [NBUF][NPOS];

  typedef struct packed {
    ccf_state_t       st;
    logic [BUFW-1:0]  cur_buf;
    logic [NBUF-1:0]  busy;
    logic             deadtime;
    logic             refused;
    logic             running;
    logic             done;
    logic [NPOS-1:0]  prev_found;
    logic [IDXW-1:0]  seed_idx;
    logic [AW-1:0]    seed_eta;
    logic [AW-1:0]    seed_phi;
    logic             xp_valid;
    logic [EW-1:0]    xp_em;
    logic [EW-1:0]    xp_had;
  } ccf_top_st_t;

  ccf_top_st_t q;
  ccf_top_st_t d;

  logic [NPOS-1:0]     found_v;
  logic [NPOS-1:0]     seed_v;
  logic [NPOS-1:0]     spread_v;
  logic [NPOS-1:0]     elig_v;
  logic [EW:0]         tow_e [NPOS];
  logic [NPOS*EW-1:0]  em_flat;
  logic [NPOS*EW-1:0]  had_flat;
  logic                l1_take;
  logic                pick_ok;
  logic [IDXW-1:0]     pick_idx;
  logic [AW-1:0]       pick_eta;
  logic [AW-1:0]       pick_phi;
  logic                sum_go;
  logic                sum_idle;

  assign l1_take = l1_accept && !q.busy[l1_buf]; // see RULE_16

  always_ff @(posedge clk) begin
    if (tw_we && (tw_idx < IDXW'(NPOS))) begin
      xing_em[tw_idx]  <= tw_em; // see RULE_13
      xing_had[tw_idx] <= tw_had;
    end
    if (l1_take) begin
      for (int i = 0; i < NPOS; i++) begin
        l2_em[l1_buf][i]  <= xing_em[i]; // see RULE_13
        l2_had[l1_buf][i] <= xing_had[i];
      end
    end
  end

  // ----------------------------------------
  // Cell array with neighbour links
  // ----------------------------------------
  for (genvar e = 0; e < ETA_N; e++) begin : g_eta
    for (genvar p = 0; p < PHI_N; p++) begin : g_phi
      localparam int I  = e * PHI_N + p;
      localparam int PU = e * PHI_N + (p + 1) % PHI_N;
      localparam int PD = e * PHI_N + (p + PHI_N - 1) % PHI_N;
      logic [3:0] nbr;
      assign nbr[0] = found_v[PU]; // see RULE_21
      assign nbr[1] = found_v[PD];
      if (e < ETA_N - 1) begin : g_hi
        assign nbr[2] = found_v[I+PHI_N];
      end else begin : g_hi_edge
        assign nbr[2] = 1'b0; // see RULE_21
      end
      if (e > 0) begin : g_lo
        assign nbr[3] = found_v[I-PHI_N];
      end else begin : g_lo_edge
        assign nbr[3] = 1'b0;
      end
      // Thresholds use the EM plus HAD sum of the position
      assign tow_e[I] = {1'b0, l2_em[q.cur_buf][I]} + {1'b0, l2_had[q.cur_buf][I]}; // see RULE_17
      assign em_flat[I*EW +: EW]  = l2_em[q.cur_buf][I];
      assign had_flat[I*EW +: EW] = l2_had[q.cur_buf][I];

      ccf_cell u_cell (
        .clk       (clk),
        .srst      (srst),
        .clr       (q.st == ST_LOAD),
        .load      (q.st == ST_LOAD),
        .energy    (tow_e[I]),
        .seed_thr  (seed_thr),
        .shldr_thr (shldr_thr),
        .plant     ((q.st == ST_PLANT) && (q.seed_idx == IDXW'(I))),
        .grow      (q.st == ST_GROW),
        .nbr_found (nbr),
        .is_seed   (seed_v[I]),
        .found     (found_v[I]),
        .spreading (spread_v[I])
      );
    end
  end

  // ----------------------------------------
  // Seed poll: lowest eta, then lowest phi
  // ----------------------------------------
  assign elig_v = seed_v & ~found_v; // see RULE_07

  always_comb begin
    pick_ok  = 1'b0;
    pick_idx = '0;
    pick_eta = '0;
    pick_phi = '0;
    for (int e = ETA_N - 1; e >= 0; e--) begin
      for (int p = PHI_N - 1; p >= 0; p--) begin
        if (elig_v[e*PHI_N+p]) begin // see RULE_03
          pick_ok  = 1'b1;
          pick_idx = IDXW'(e * PHI_N + p);
          pick_eta = AW'(e);
          pick_phi = AW'(p);
        end
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.xp_valid = 1'b0;
    sum_go     = 1'b0;
    d.refused  = l1_accept && q.busy[l1_buf]; // see RULE_16
    if (l2_release) begin
      d.busy[l2_release_buf] = 1'b0;
    end
    if (l1_take) begin
      d.busy[l1_buf] = 1'b1;
    end
    // Expansion reads use their own port, never the cluster path
    if (xp_rd_idx < IDXW'(NPOS)) begin
      d.xp_em  = l2_em[q.cur_buf][xp_rd_idx]; // see RULE_20
      d.xp_had = l2_had[q.cur_buf][xp_rd_idx];
    end else begin
      d.xp_em  = '0;
      d.xp_had = '0;
    end
    case (q.st)
      ST_IDLE: begin
        if (proc_req) begin // see RULE_14
          d.cur_buf        = proc_buf;
          d.busy[proc_buf] = 1'b1;
          d.st             = ST_LOAD;
        end
      end
      ST_LOAD: begin
        d.prev_found = '0; // see RULE_22
        d.st         = ST_SEED;
      end
      ST_SEED: begin
        if (pick_ok) begin // see RULE_09
          d.seed_idx = pick_idx;
          d.seed_eta = pick_eta;
          d.seed_phi = pick_phi;
          d.st       = ST_PLANT;
        end else begin
          d.st = ST_DRAIN;
        end
      end
      ST_PLANT: begin
        d.xp_valid = 1'b1; // see RULE_20
        d.st       = ST_GROW;
      end
      ST_GROW: begin
        if (spread_v == '0) begin // see RULE_06
          sum_go       = 1'b1; // see RULE_08
          d.prev_found = found_v;
          d.st         = ST_SEED; // see RULE_10
        end
      end
      ST_DRAIN: begin
        if (sum_idle) begin // see RULE_15
          d.done = 1'b1;
          d.st   = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    d.running  = d.st != ST_IDLE;
    d.deadtime = &d.busy; // see RULE_16
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.busy <= BUSY_RST;
    end else begin
      q <= d;
    end
  end

  // Only towers new to this cluster are summed
  ccf_sum u_sum (
    .clk      (clk),
    .srst     (srst),
    .go       (sum_go),
    .mask     (found_v & ~q.prev_found), // see RULE_02
    .em_flat  (em_flat),
    .had_flat (had_flat),
    .seed_eta (q.seed_eta),
    .seed_phi (q.seed_phi),
    .valid    (clu_valid),
    .em       (clu_em),
    .had      (clu_had),
    .cnt      (clu_count),
    .eta      (clu_eta),
    .phi      (clu_phi),
    .idle     (sum_idle)
  );

  assign l1_refused    = q.refused;
  assign deadtime      = q.deadtime;
  assign buf_busy      = q.busy;
  assign finder_busy   = q.running;
  assign event_done    = q.done;
  assign xp_addr_valid = q.xp_valid;
  assign xp_eta        = q.seed_eta;
  assign xp_phi        = q.seed_phi;
  assign xp_em         = q.xp_em;
  assign xp_had        = q.xp_had;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  refuse_busy_a: // see RULE_16
    assert property (l1_accept && q.busy[l1_buf] |=> l1_refused && buf_busy[$past(l1_buf)])
      else $error("accept into occupied buffer not refused");
  start_now_a: // see RULE_14
    assert property (q.st == ST_IDLE && proc_req |=> q.st == ST_LOAD && finder_busy)
      else $error("buffer address did not start finding");
  hold_buf_a: // see RULE_15
    assert property (q.st != ST_IDLE && q.st != ST_LOAD |=> $stable(q.cur_buf))
      else $error("buffer changed during finding");
  clear_found_a: // see RULE_22
    assert property (q.st == ST_LOAD |=> found_v == '0)
      else $error("found flags not cleared");
  seed_order_a: // see RULE_03
    assert property (q.st == ST_SEED && pick_ok |-> (elig_v & ~({NPOS{1'b1}} << pick_idx)) == '0)
      else $error("seed not lowest eta then phi");
  seed_only_a: // see RULE_07
    assert property (q.st == ST_PLANT |-> seed_v[q.seed_idx] && !found_v[q.seed_idx])
      else $error("cluster started at non-seed or found tower");
  plant_found_a: // see RULE_04
    assert property (q.st == ST_PLANT |=> found_v[$past(q.seed_idx)] && xp_addr_valid)
      else $error("seed not marked found");
  grow_end_a: // see RULE_06
    assert property (q.st == ST_GROW && spread_v == '0 |=> q.st == ST_SEED ##2 clu_valid)
      else $error("complete cluster not summed in time");
  overlap_a: // see RULE_10
    assert property (sum_go |=> !sum_idle && q.st == ST_SEED)
      else $error("seed search waited on summing");
  event_end_a: // see RULE_09
    assert property (q.st == ST_SEED && !pick_ok |-> ##[2:5] event_done)
      else $error("event not finished after last cluster");

  cluster_c:   cover property (clu_valid);
  two_clu_c:   cover property (q.st == ST_SEED && pick_ok && q.prev_found != '0);
  event_c:     cover property (event_done);
  deadtime_c:  cover property (deadtime ##1 l1_accept);

endmodule

// ==== logic/ccf_pkg.sv ====
// Shared constants and state encoding of the Level-2 cluster finder.
// Assumes one trigger clock for every part of the finder.
package ccf_pkg;

  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int ETA_N         = 24;
  localparam int PHI_N         = 24;
  localparam int NPOS          = ETA_N * PHI_N;
  localparam int EW            = 8;
  localparam int NBUF          = 4;
  localparam int BUFW          = 2;
  localparam int IDXW          = 10;
  localparam int AW            = 5;

  // ----------------------------------------
  // Summing hierarchy: board, crate, master
  // ----------------------------------------
  localparam int BRD_POS       = 8;
  localparam int NBRD          = NPOS / BRD_POS;
  localparam int NCRATE        = 6;
  localparam int BRD_PER_CRATE = NBRD / NCRATE;
  localparam int BSW           = EW + 3;
  localparam int CSW           = BSW + 4;
  localparam int SUMW          = CSW + 3;
  localparam int BCW           = 4;
  localparam int CCW           = 7;
  localparam int CNTW          = 10;
  localparam int SUM_LAT       = 3;

  // ----------------------------------------
  // Reset values and states
  // ----------------------------------------
  localparam logic [NBUF-1:0] BUSY_RST = 4'h0;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_LOAD  = 6'h02,
    ST_SEED  = 6'h04,
    ST_PLANT = 6'h08,
    ST_GROW  = 6'h10,
    ST_DRAIN = 6'h20
  } ccf_state_t;

endpackage

// ==== logic/ccf_cell.sv ====
// One tower position of the cluster search: thresholds and found flag.
// Assumes energy and thresholds are stable while load is high.
`timescale 1ns/1ps

module ccf_cell
  import ccf_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          clr,
  input  wire logic          load,
  input  wire logic [EW:0]   energy,
  input  wire logic [EW:0]   seed_thr,
  input  wire logic [EW:0]   shldr_thr,
  input  wire logic          plant,
  input  wire logic          grow,
  input  wire logic [3:0]    nbr_found,
  output logic               is_seed,
  output logic               found,
  output logic               spreading
);

  typedef struct packed {
    logic above_seed;
    logic above_shldr;
    logic found;
  } ccf_cell_st_t;

  ccf_cell_st_t q;
  ccf_cell_st_t d;

  always_comb begin
    d = q;
    spreading = grow && !q.found && q.above_shldr && (|nbr_found); // see RULE_05
    if (clr) begin
      d.found = 1'b0; // see RULE_22
    end
    if (load) begin
      d.above_seed  = energy > seed_thr; // see RULE_01
      d.above_shldr = energy > shldr_thr; // see RULE_01
    end
    if (plant || spreading) begin
      d.found = 1'b1; // see RULE_04
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign is_seed = q.above_seed;
  assign found   = q.found;

endmodule

// ==== logic/ccf_sum.sv ====
// Three-stage adder tree: board sums, crate sums, master sum.
// Assumes mask and energies are valid in the cycle go is high.
`timescale 1ns/1ps

module ccf_sum
  import ccf_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 go,
  input  wire logic [NPOS-1:0]      mask,
  input  wire logic [NPOS*EW-1:0]   em_flat,
  input  wire logic [NPOS*EW-1:0]   had_flat,
  input  wire logic [AW-1:0]        seed_eta,
  input  wire logic [AW-1:0]        seed_phi,
  output logic                      valid,
  output logic [SUMW-1:0]           em,
  output logic [SUMW-1:0]           had,
  output logic [CNTW-1:0]           cnt,
  output logic [AW-1:0]             eta,
  output logic [AW-1:0]             phi,
  output logic                      idle
);

  typedef struct packed {
    logic [NBRD-1:0][BSW-1:0]   b_em;
    logic [NBRD-1:0][BSW-1:0]   b_had;
    logic [NBRD-1:0][BCW-1:0]   b_cnt;
    logic [NCRATE-1:0][CSW-1:0] c_em;
    logic [NCRATE-1:0][CSW-1:0] c_had;
    logic [NCRATE-1:0][CCW-1:0] c_cnt;
    logic [SUMW-1:0]            em;
    logic [SUMW-1:0]            had;
    logic [CNTW-1:0]            cnt;
    logic [AW-1:0]              eta1;
    logic [AW-1:0]              phi1;
    logic [AW-1:0]              eta2;
    logic [AW-1:0]              phi2;
    logic [AW-1:0]              eta;
    logic [AW-1:0]              phi;
    logic                       v1;
    logic                       v2;
    logic                       v3;
  } ccf_sum_st_t;

  ccf_sum_st_t q;
  ccf_sum_st_t d;

  always_comb begin
    d = q;
    d.v1   = go;
    d.v2   = q.v1;
    d.v3   = q.v2;
    d.eta1 = seed_eta;
    d.phi1 = seed_phi;
    d.eta2 = q.eta1;
    d.phi2 = q.phi1;
    d.eta  = q.eta2; // see RULE_12
    d.phi  = q.phi2;
    // Board stage: eight positions, EM and HAD apart
    for (int b = 0; b < NBRD; b++) begin
      d.b_em[b]  = '0;
      d.b_had[b] = '0;
      d.b_cnt[b] = '0;
      for (int k = 0; k < BRD_POS; k++) begin
        if (mask[b*BRD_POS+k]) begin // see RULE_08
          d.b_em[b]  = d.b_em[b] + BSW'(em_flat[(b*BRD_POS+k)*EW +: EW]); // see RULE_18
          d.b_had[b] = d.b_had[b] + BSW'(had_flat[(b*BRD_POS+k)*EW +: EW]);
          d.b_cnt[b] = d.b_cnt[b] + BCW'(1);
        end
      end
    end
    for (int c = 0; c < NCRATE; c++) begin
      d.c_em[c]  = '0;
      d.c_had[c] = '0;
      d.c_cnt[c] = '0;
      for (int j = 0; j < BRD_PER_CRATE; j++) begin
        d.c_em[c]  = d.c_em[c] + CSW'(q.b_em[c*BRD_PER_CRATE+j]); // see RULE_19
        d.c_had[c] = d.c_had[c] + CSW'(q.b_had[c*BRD_PER_CRATE+j]);
        d.c_cnt[c] = d.c_cnt[c] + CCW'(q.b_cnt[c*BRD_PER_CRATE+j]);
      end
    end
    d.em  = '0;
    d.had = '0;
    d.cnt = '0;
    for (int c = 0; c < NCRATE; c++) begin
      d.em  = d.em + SUMW'(q.c_em[c]); // see RULE_11
      d.had = d.had + SUMW'(q.c_had[c]);
      d.cnt = d.cnt + CNTW'(q.c_cnt[c]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid = q.v3;
  assign em    = q.em;
  assign had   = q.had;
  assign cnt   = q.cnt;
  assign eta   = q.eta;
  assign phi   = q.phi;
  assign idle  = !(q.v1 || q.v2 || q.v3);

endmodule

// ==== logic/ccf_finder_end.sv ====
// Holds no logic of its own.
// Assumes the finder sources are read before it.
`timescale 1ns/1ps

// ==== testbench/ccf_l2_model.sv ====
// Level-2 processor model: records cluster reports, frees a buffer.
// Assumes every finder output is registered on clk.
`timescale 1ns/1ps

module ccf_l2_model
  import ccf_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            clu_valid,
  input  wire logic [SUMW-1:0] clu_em,
  input  wire logic [SUMW-1:0] clu_had,
  input  wire logic [CNTW-1:0] clu_count,
  input  wire logic [AW-1:0]   clu_eta,
  input  wire logic [AW-1:0]   clu_phi,
  input  wire logic            xp_addr_valid,
  input  wire logic            event_done,
  input  wire logic            rel_en,
  input  wire logic [BUFW-1:0] rel_buf,
  output logic                 l2_release,
  output logic [BUFW-1:0]      l2_release_buf
);
  logic [SUMW-1:0] em_q  [16];
  logic [SUMW-1:0] had_q [16];
  logic [CNTW-1:0] cnt_q [16];
  logic [AW-1:0]   eta_q [16];
  logic [AW-1:0]   phi_q [16];
  logic            pend_q;
  int              n_clu;
  int              n_xp;

  // ----
  // Frees a buffer two cycles after its event is complete
  // ----
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q         <= 1'b0;
      l2_release     <= 1'b0;
      l2_release_buf <= 2'h0;
      n_clu          <= 0;
      n_xp           <= 0;
    end else begin
      pend_q         <= event_done & rel_en;
      l2_release     <= pend_q;
      // Idle select shows garbage, never the last buffer
      l2_release_buf <= pend_q ? rel_buf : ~rel_buf;
      if (xp_addr_valid) begin
        n_xp <= n_xp + 1;
      end
      if (clu_valid && n_clu < 16) begin
        em_q[n_clu]  <= clu_em;
        had_q[n_clu] <= clu_had;
        cnt_q[n_clu] <= clu_count;
        eta_q[n_clu] <= clu_eta;
        phi_q[n_clu] <= clu_phi;
        n_clu        <= n_clu + 1;
      end
    end
  end
endmodule

// ==== testbench/calorimeter_cluster_finder_test.sv ====
// Self-checking bench of the cluster finder with a processor model.
// Assumes one clock; the bench plays the digitizer and supervisor.
`timescale 1ns/1ps

module calorimeter_cluster_finder_test
  import ccf_pkg::*;
;
  logic            clk, srst, tw_we, l1_accept, proc_req, l2_release, rel_en;
  logic [IDXW-1:0] tw_idx, xp_rd_idx;
  logic [EW-1:0]   tw_em, tw_had, xp_em, xp_had;
  logic [BUFW-1:0] l1_buf, l2_release_buf, proc_buf, rel_buf;
  logic [EW:0]     seed_thr, shldr_thr;
  logic            l1_refused, deadtime, finder_busy, event_done;
  logic            clu_valid, xp_addr_valid, r;
  logic [NBUF-1:0] buf_busy;
  logic [SUMW-1:0] clu_em, clu_had;
  logic [CNTW-1:0] clu_count;
  logic [AW-1:0]   clu_eta, clu_phi, xp_eta, xp_phi;
  int              errors, n_tests;

  // Expected clusters: eta, phi, em, had, count, in seed order
  localparam int EXP [3][5] = '{'{1, 5, 250, 50, 3}, '{4, 23, 135, 5, 2},
                                '{23, 10, 200, 0, 1}};

  ccf_finder dut (.clk(clk), .srst(srst), .tw_we(tw_we), .tw_idx(tw_idx),
    .tw_em(tw_em), .tw_had(tw_had), .l1_accept(l1_accept), .l1_buf(l1_buf),
    .l2_release(l2_release), .l2_release_buf(l2_release_buf),
    .proc_req(proc_req), .proc_buf(proc_buf), .seed_thr(seed_thr),
    .shldr_thr(shldr_thr), .xp_rd_idx(xp_rd_idx), .l1_refused(l1_refused),
    .deadtime(deadtime), .buf_busy(buf_busy), .finder_busy(finder_busy),
    .event_done(event_done), .clu_valid(clu_valid), .clu_em(clu_em),
    .clu_had(clu_had), .clu_count(clu_count), .clu_eta(clu_eta),
    .clu_phi(clu_phi), .xp_addr_valid(xp_addr_valid), .xp_eta(xp_eta),
    .xp_phi(xp_phi), .xp_em(xp_em), .xp_had(xp_had));

  ccf_l2_model p (.clk(clk), .srst(srst), .clu_valid(clu_valid),
    .clu_em(clu_em), .clu_had(clu_had), .clu_count(clu_count),
    .clu_eta(clu_eta), .clu_phi(clu_phi), .xp_addr_valid(xp_addr_valid),
    .event_done(event_done), .rel_en(rel_en), .rel_buf(rel_buf),
    .l2_release(l2_release), .l2_release_buf(l2_release_buf));

  always #10 clk = ~clk;

  // ----
  // Shared helpers
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Event: two seeds touch, phi wrap pair, eta edge pair, seed at threshold
  function automatic logic [15:0] tw_val(input int i);
    case (i)
      29:      return 16'h6432;
      30:      return 16'h1E00;
      31:      return 16'h7800;
      119:     return 16'h6E00;
      96:      return 16'h1905;
      562:     return 16'hC800;
      10:      return 16'h3200;
      250:     return 16'h6400;
      default: return 16'h0000;
    endcase
  endfunction

  // ----
  // Scenarios
  // ----
  task automatic t_write();
    for (int i = 0; i < NPOS; i++) begin
      @(posedge clk);
      tw_we  <= 1'b1;
      tw_idx <= i[IDXW-1:0];
      {tw_em, tw_had} <= tw_val(i);
    end
    // Out-of-range index must not alias onto a real position
    @(posedge clk);
    tw_idx <= 10'h258;
    {tw_em, tw_had} <= 16'hFFFF;
    @(posedge clk);
    tw_we <= 1'b0;
  endtask

  task automatic accept(input logic [BUFW-1:0] b, output logic refused);
    @(posedge clk);
    l1_accept <= 1'b1;
    l1_buf    <= b;
    @(posedge clk);
    l1_accept <= 1'b0;
    refused = 1'b0;
    repeat (3) begin
      #1;
      refused |= l1_refused;
      @(posedge clk);
    end
    #1;
  endtask

  task automatic find(input logic [BUFW-1:0] b, input logic [NBUF-1:0] exp_busy);
    int base;
    int k;
    base = p.n_clu;
    @(posedge clk);
    proc_req <= 1'b1;
    proc_buf <= b;
    @(posedge clk);
    proc_req <= 1'b0;
    #1;
    chk("finder_busy", 1, finder_busy);
    // A second request mid-event must be ignored
    @(posedge clk);
    proc_req <= 1'b1;
    proc_buf <= 2'h2;
    @(posedge clk);
    proc_req <= 1'b0;
    k = 0;
    while (event_done !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("event_done", 1, event_done);
    chk("clusters", 3, p.n_clu - base);
    for (int i = 0; i < 3; i++) begin
      chk("eta", EXP[i][0], p.eta_q[base+i]);
      chk("phi", EXP[i][1], p.phi_q[base+i]);
      chk("em", EXP[i][2], p.em_q[base+i]);
      chk("had", EXP[i][3], p.had_q[base+i]);
      chk("count", EXP[i][4], p.cnt_q[base+i]);
    end
    chk("xp seeds", p.n_clu, p.n_xp);
    chk("xp_eta", EXP[2][0], xp_eta);
    chk("xp_phi", EXP[2][1], xp_phi);
    @(posedge clk);
    #1;
    chk("finder_busy", 0, finder_busy);
    chk("buf_busy", exp_busy, buf_busy);
  endtask

  task automatic t_xp();
    @(posedge clk);
    xp_rd_idx <= 10'h01D;
    @(posedge clk);
    xp_rd_idx <= 10'h258;
    #1;
    chk("xp_em", 8'h64, xp_em);
    chk("xp_had", 8'h32, xp_had);
    @(posedge clk);
    #1;
    chk("xp_em", 8'h00, xp_em);
  endtask

  task automatic t_full();
    accept(2'h0, r);
    chk("l1_refused", 1, r);
    accept(2'h1, r);
    accept(2'h2, r);
    chk("deadtime", 0, deadtime);
    accept(2'h3, r);
    chk("l1_refused", 0, r);
    chk("deadtime", 1, deadtime);
    chk("buf_busy", 4'hF, buf_busy);
    @(posedge clk);
    rel_en <= 1'b1;
    find(2'h3, 4'hF);
    repeat (4) @(posedge clk);
    #1;
    chk("buf_busy", 4'h7, buf_busy);
    chk("deadtime", 0, deadtime);
  endtask

  initial begin
    clk       = 1'b0;
    srst      = 1'b1;
    {tw_we, l1_accept, proc_req, rel_en} = 4'h0;
    {tw_idx, xp_rd_idx} = 20'h00000;
    {tw_em, tw_had} = 16'h0000;
    {l1_buf, proc_buf} = 4'h0;
    rel_buf   = 2'h3;
    seed_thr  = 9'h064;
    shldr_thr = 9'h014;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk("buf_busy", 4'h0, buf_busy);
    chk("finder_busy", 0, finder_busy);
    t_write();
    accept(2'h0, r);
    chk("l1_refused", 0, r);
    chk("buf_busy", 4'h1, buf_busy);
    find(2'h0, 4'h1);
    t_xp();
    find(2'h0, 4'h1);
    t_full();
    finish_test();
  end

  // Whole run needs about 750 cycles; 20000 leaves ample margin
  initial begin
    #400000;
    errors++;
    finish_test();
  end
endmodule
